// File: shift_scanner.sv
// stand-alone scanner for a chain of external shift registers
// Summary of operation
// RULE1: up to 32 eight-bit registers each way
// RULE2: count chain length using the tap input
// RULE3: MSB first, bits move on rising clock
// RULE4: pulse load low before and after transfer
// RULE5: input byte 0 received first
// RULE6: output byte 31 sent first, byte 0 last; code sends byte nbytes-1 first, which is byte 31 only for a 32-register chain
// RULE7: process active output high only when active
// RULE8: board clears outputs while flag low
// RULE9: board straps mode pattern 0,1,0
// RULE10: sample four straps at startup only
// RULE11: one unsigned byte item per register
// RULE12: access codes 09h input, 11h output
// RULE13: read switches at setup, then each 0.5s
// RULE14: clock quiet while load asserted
`timescale 1ns/1ps
`default_nettype none
`include "scan_cfg.svh"
module shift_scanner import scan_pkg::*; #(
    parameter int SWITCH_CYCLES = `SWITCH_CYC
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic mode_strap_bit0_in,
    input wire logic mode_strap_bit1_in,
    input wire logic mode_strap_bit2_in,
    input wire logic mode_strap_bit3_in,
    input wire logic chain_serial_in,
    input wire logic chain_length_tap_in,
    input wire logic net_active_in,
    input wire logic [7:0] node_address_switch_in,
    input wire logic [7:0] rate_or_id_switch_in,
    input wire logic [7:0] out_byte_in [32],
    input wire logic black_channel_data_in,
    output logic shift_load_n_out,
    output logic shift_clk_out,
    output logic serial_out,
    output logic process_active_flag_out,
    output logic black_channel_out,
    output logic black_channel_oe_out,
    output logic mode_ok_out,
    output unsigned_byte_type in_byte_out [32],
    output logic [5:0] in_count_out,
    output logic [5:0] out_count_out,
    output logic [7:0] in_access_out,
    output logic [7:0] out_access_out,
    output logic [7:0] node_address_out,
    output logic [7:0] rate_or_id_out,
    output logic switch_update_out,
    output logic scan_done_out
);
    localparam logic [7:0] HALF = 8'(`HALF_CLK_CYC); // cycles per clock phase
    scan_state_e state; // sequencer state
    logic [7:0] tmr; // phase and load timer
    logic [2:0] bitn; // bit within byte
    logic [5:0] byten; // byte position in chain
    logic [5:0] nbytes; // chain length used for shifting
    logic detect; // first frame detects length
    logic [7:0] sh_in; // incoming byte assembler
    logic clk_lvl; // requested clock level
    logic [31:0] sw_tmr; // switch sample timer
    shift_bus_if bus ();

    // pin stage instance
    shift_pin_stage u_pins (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .bus(bus),
        .shift_load_n_out(shift_load_n_out),
        .shift_clk_out(shift_clk_out),
        .serial_out(serial_out)
    );

    // output byte index: highest first, byte 0 last
    function automatic logic [4:0] out_index(input logic [5:0] pos,
                                             input logic [5:0] n);
        out_index = 5'(n - 6'd1 - pos); // RULE6
    endfunction : out_index

    // request signals for the pin stage
    assign bus.load_req = (state == ST_LOAD_PRE) || (state == ST_LOAD_POST); // RULE4
    assign bus.clk_level = clk_lvl;
    assign bus.data_bit = (state == ST_SHIFT) ?
        out_byte_in[out_index(byten, nbytes)][3'd7 - bitn] : 1'b0; // RULE3
    assign in_access_out = `ACC_INPUT; // RULE12
    assign out_access_out = `ACC_OUTPUT; // RULE12
    assign black_channel_out = black_channel_data_in;
    assign black_channel_oe_out = (state != ST_STRAP); // RULE10
    assign process_active_flag_out = net_active_in && mode_ok_out &&
        scan_done_out; // RULE7

    // strap capture on the first clock after reset release
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            mode_ok_out <= 1'b0;
        end else if (state == ST_STRAP) begin
            // RULE10 RULE9
            mode_ok_out <= ({mode_strap_bit3_in, mode_strap_bit2_in,
                mode_strap_bit1_in, mode_strap_bit0_in} == `MODE_SHIFT);
        end
    end

    // main scan sequencer
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= ST_STRAP;
            tmr <= 8'h00;
            bitn <= 3'h0;
            byten <= 6'h00;
            nbytes <= `MAX_REGS; // RULE1
            detect <= 1'b1;
            clk_lvl <= 1'b0;
            scan_done_out <= 1'b0;
        end else begin
            unique case (state)
                ST_STRAP: begin
                    // straps are read now; wrong pattern parks the block
                    state <= ({mode_strap_bit3_in, mode_strap_bit2_in,
                        mode_strap_bit1_in, mode_strap_bit0_in} ==
                        `MODE_SHIFT) ? ST_LOAD_PRE : ST_OFF;
                    tmr <= 8'h00;
                end
                ST_LOAD_PRE: begin
                    // latch parallel inputs before shifting
                    if (tmr == `LOAD_CYC - 8'h01) begin
                        state <= ST_SHIFT;
                        tmr <= 8'h00;
                        bitn <= 3'h0;
                        byten <= 6'h00;
                    end else begin
                        tmr <= tmr + 8'h01;
                    end
                end
                ST_SHIFT: begin
                    // half period timer toggles clock
                    if (tmr == HALF - 8'h01) begin
                        tmr <= 8'h00;
                        clk_lvl <= ~clk_lvl;
                        if (clk_lvl) begin
                            // falling edge: advance bit
                            bitn <= bitn + 3'h1;
                            if (bitn == 3'h7) begin
                                byten <= byten + 6'h01;
                                // RULE2: tap marks end of chain
                                if ((detect && chain_length_tap_in) ||
                                    (byten + 6'h01 == nbytes)) begin
                                    if (detect) begin
                                        nbytes <= byten + 6'h01;
                                    end
                                    state <= ST_LOAD_POST;
                                end
                            end
                        end
                    end else begin
                        tmr <= tmr + 8'h01;
                    end
                end
                ST_LOAD_POST: begin
                    // latch new outputs after shifting
                    clk_lvl <= 1'b0;
                    if (tmr == `LOAD_CYC - 8'h01) begin
                        state <= ST_LOAD_PRE;
                        tmr <= 8'h00;
                        detect <= 1'b0;
                        scan_done_out <= 1'b1;
                    end else begin
                        tmr <= tmr + 8'h01;
                    end
                end
                ST_IDLE: state <= ST_LOAD_PRE;
                ST_OFF: state <= ST_OFF;
                default: state <= ST_OFF;
            endcase
        end
    end

    assign in_count_out = nbytes; // RULE11
    assign out_count_out = nbytes; // RULE11

    // input assembly on rising clock edge, byte 0 first
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sh_in <= 8'h00;
            for (int i = 0; i < 32; i++) begin
                in_byte_out[i] <= 8'h00;
            end
        end else if (state == ST_SHIFT && tmr == HALF - 8'h01 && !clk_lvl) begin
            sh_in <= {sh_in[6:0], chain_serial_in}; // RULE3
            if (bitn == 3'h7) begin
                in_byte_out[byten[4:0]] <= {sh_in[6:0], chain_serial_in}; // RULE5
            end
        end
    end

    // switch sampling at setup and every half second
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sw_tmr <= 32'h0;
            node_address_out <= 8'h00;
            rate_or_id_out <= 8'h00;
            switch_update_out <= 1'b0;
        end else begin
            switch_update_out <= 1'b0;
            if (state == ST_STRAP || sw_tmr == 32'(SWITCH_CYCLES - 1)) begin
                sw_tmr <= 32'h0;
                node_address_out <= node_address_switch_in; // RULE13
                rate_or_id_out <= rate_or_id_switch_in;
                switch_update_out <= (state == ST_STRAP) ||
                    (node_address_switch_in != node_address_out) ||
                    (rate_or_id_switch_in != rate_or_id_out); // RULE13
            end else begin
                sw_tmr <= sw_tmr + 32'h1;
            end
        end
    end

    property p_clk_quiet_load; // RULE14
        @(posedge clk_in) disable iff (!rstn_in)
        !shift_load_n_out |-> !shift_clk_out;
    endproperty
    a_clk_quiet_load: assert property (p_clk_quiet_load) // RULE14
        else $error("clock moved during load");

    property p_load_around; // RULE4
        @(posedge clk_in) disable iff (!rstn_in)
        (state == ST_SHIFT) ##1 (state == ST_LOAD_POST) |->
            ##1 !shift_load_n_out;
    endproperty
    a_load_around: assert property (p_load_around) // RULE4
        else $error("no load after transfer");

    property p_active_flag; // RULE7
        @(posedge clk_in) disable iff (!rstn_in)
        process_active_flag_out |-> state != ST_STRAP && state != ST_OFF;
    endproperty
    a_active_flag: assert property (p_active_flag) // RULE7
        else $error("active flag while not scanning");

    property p_len_bound; // RULE1
        @(posedge clk_in) disable iff (!rstn_in)
        nbytes <= `MAX_REGS && nbytes != 6'h00;
    endproperty
    a_len_bound: assert property (p_len_bound) // RULE1
        else $error("chain length out of range");

    property p_access; // RULE12
        @(posedge clk_in) disable iff (!rstn_in)
        in_access_out == 8'h09 && out_access_out == 8'h11;
    endproperty
    a_access: assert property (p_access) // RULE12
        else $error("access code wrong");

    property p_strap_once; // RULE10
        @(posedge clk_in) disable iff (!rstn_in)
        state != ST_STRAP |=> $stable(mode_ok_out);
    endproperty
    a_strap_once: assert property (p_strap_once) // RULE10
        else $error("mode changed after startup");

    property p_sw_first; // RULE13
        @(posedge clk_in) disable iff (!rstn_in)
        state == ST_STRAP |=> switch_update_out;
    endproperty
    a_sw_first: assert property (p_sw_first) // RULE13
        else $error("switches not read at setup");

    property p_pre_load; // RULE4
        @(posedge clk_in) disable iff (!rstn_in)
        (state == ST_LOAD_PRE) ##1 (state == ST_SHIFT) |->
            !$past(shift_load_n_out);
    endproperty
    a_pre_load: assert property (p_pre_load) // RULE4
        else $error("no load before transfer");
endmodule : shift_scanner
`default_nettype wire

// File: scan_cfg.svh
// constants for the shift register chain scanner
`ifndef SCAN_CFG_SVH
`define SCAN_CFG_SVH
`define MAX_REGS 6'd32
`define ACC_INPUT 8'h09
`define ACC_OUTPUT 8'h11
`define MODE_SHIFT 4'h2
`define HALF_CLK_NS 8
`define HALF_CLK_CYC ((`HALF_CLK_NS + 3) / 4)
`define SWITCH_NS 500000000
`define SWITCH_CYC ((`SWITCH_NS) / 4)
`define LOAD_CYC 8'd4
`endif

// File: scan_pkg.sv
// types for the shift register chain scanner
`default_nettype none
package scan_pkg;
    typedef enum logic [3:0] {
        ST_STRAP = 4'h0,
        ST_LOAD_PRE = 4'h1,
        ST_SHIFT = 4'h2,
        ST_LOAD_POST = 4'h3,
        ST_IDLE = 4'h4,
        ST_OFF = 4'h5
    } scan_state_e;
    typedef logic [7:0] unsigned_byte_type;
endpackage : scan_pkg
`default_nettype wire

// File: shift_bus_if.sv
// carrier between sequencer and pin stage
`timescale 1ns/1ps
`default_nettype none
interface shift_bus_if;
    logic load_req; // request load low
    logic clk_level; // requested shift clock level
    logic data_bit; // next serial out bit
    modport seq (output load_req, output clk_level, output data_bit);
    modport pins (input load_req, input clk_level, input data_bit);
endinterface : shift_bus_if
`default_nettype wire

// File: shift_pin_stage.sv
// registered pin stage for load, clock and data
`timescale 1ns/1ps
`default_nettype none
module shift_pin_stage (
    input wire logic clk_in,
    input wire logic rstn_in,
    shift_bus_if.pins bus,
    output logic shift_load_n_out,
    output logic shift_clk_out,
    output logic serial_out
);
    // registers the requested pin levels; clock held while loading
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            shift_load_n_out <= 1'b1;
            shift_clk_out <= 1'b0;
            serial_out <= 1'b0;
        end else begin
            shift_load_n_out <= ~bus.load_req;
            shift_clk_out <= bus.load_req ? 1'b0 : bus.clk_level; // RULE14
            serial_out <= bus.data_bit;
        end
    end
endmodule : shift_pin_stage
`default_nettype wire

// File: shift_chain_model.sv
// behavioural chain of external eight-bit shift registers
`timescale 1ns/1ps
`default_nettype none
module shift_chain_model (
    input wire logic shift_clk_in,
    input wire logic shift_load_n_in,
    input wire logic data_in,
    input wire logic active_in,
    input wire logic [5:0] n_regs_in,
    input wire logic [7:0] par_in [32],
    output logic data_out,
    output logic tap_out,
    output logic [7:0] par_out [32]
);
    logic [255:0] in_sr; // input registers, byte 0 nearest
    logic [255:0] out_sr; // output registers, last byte in low bits
    logic [8:0] bit_cnt; // bits moved since the last load
    // first input register drives the line
    assign data_out = in_sr[255];
    // tap rises once the whole chain has been clocked through
    assign tap_out = (bit_cnt >= {n_regs_in, 3'b000});
    // load while strobe low, else shift on rising clock
    always @(posedge shift_clk_in or negedge shift_load_n_in) begin
        if (!shift_load_n_in) begin
            for (int k = 0; k < 32; k++) begin
                in_sr[255 - 8 * k -: 8] <= par_in[k];
                // outputs held cleared while not active
                par_out[k] <= active_in ? out_sr[8 * k +: 8] : 8'h00;
            end
            bit_cnt <= 9'h000;
        end else begin
            in_sr <= {in_sr[254:0], 1'b0};
            out_sr <= {out_sr[254:0], data_in};
            bit_cnt <= bit_cnt + 9'h001;
        end
    end
endmodule : shift_chain_model
`default_nettype wire

// File: test_shift_scanner.sv
// self-checking bench for the shift register chain scanner
`timescale 1ns/1ps
`default_nettype none
module test_shift_scanner;
    import scan_pkg::*;
    logic clk_in, rstn_in, net_active_in, black_channel_data_in;
    logic mode_strap_bit0_in, mode_strap_bit1_in, mode_strap_bit2_in;
    logic mode_strap_bit3_in, chain_serial_in, chain_length_tap_in;
    logic [7:0] node_address_switch_in, rate_or_id_switch_in;
    logic [7:0] out_byte_in [32]; // bytes for the output chain
    logic [7:0] in_data [32]; // bytes on the input chain
    logic [7:0] latched [32]; // output chain contents
    unsigned_byte_type in_byte_out [32];
    logic shift_load_n_out, shift_clk_out, serial_out;
    logic process_active_flag_out, mode_ok_out, scan_done_out;
    logic black_channel_out, black_channel_oe_out, switch_update_out;
    logic [5:0] in_count_out, out_count_out, n_regs;
    logic [7:0] in_access_out, out_access_out;
    logic [7:0] node_address_out, rate_or_id_out;
    logic [5:0] lens [3]; // chain lengths tried
    int errors, n_compared, seed;
    int n_upd; // switch update pulses seen
    int upd0; // pulse count before a switch change
    shift_scanner #(.SWITCH_CYCLES(50)) dut_u (.clk_in, .rstn_in,
        .mode_strap_bit0_in, .mode_strap_bit1_in, .mode_strap_bit2_in,
        .mode_strap_bit3_in, .chain_serial_in, .chain_length_tap_in,
        .net_active_in, .node_address_switch_in, .rate_or_id_switch_in,
        .out_byte_in, .black_channel_data_in, .shift_load_n_out,
        .shift_clk_out, .serial_out, .process_active_flag_out,
        .black_channel_out, .black_channel_oe_out, .mode_ok_out,
        .in_byte_out, .in_count_out, .out_count_out, .in_access_out,
        .out_access_out, .node_address_out, .rate_or_id_out,
        .switch_update_out, .scan_done_out);
    shift_chain_model chain_u (.shift_clk_in(shift_clk_out),
        .shift_load_n_in(shift_load_n_out), .data_in(serial_out),
        .active_in(process_active_flag_out), .n_regs_in(n_regs),
        .par_in(in_data), .data_out(chain_serial_in),
        .tap_out(chain_length_tap_in), .par_out(latched));
    // counts one-cycle switch update pulses
    always @(posedge clk_in) begin
        if (switch_update_out === 1'b1) n_upd <= n_upd + 1;
    end
    // clock source
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // expected contents of an output register
    function automatic logic [7:0] exp_latch(input int k, input logic act);
        return act ? out_byte_in[k] : 8'h00;
    endfunction : exp_latch
    // compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task summarize;
        if (errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize
    // reset with a given strap pattern, bit3 down to bit0
    task do_reset(input logic [3:0] s);
        @(posedge clk_in);
        rstn_in <= 1'b0;
        {mode_strap_bit3_in, mode_strap_bit2_in, mode_strap_bit1_in,
            mode_strap_bit0_in} <= s;
        repeat (2) @(posedge clk_in);
        check({7'h00, black_channel_oe_out}, 8'h00);
        rstn_in <= 1'b1;
    endtask : do_reset
    // wait for load pulses, bounded
    task wait_pulses(input int n);
        int c;
        for (int i = 0; i < n; i++) begin
            c = 0;
            while (shift_load_n_out !== 1'b0 && c < 3000) begin
                @(posedge clk_in);
                c++;
            end
            // a pulse that never comes counts as a mismatch
            if (c >= 3000) errors++;
            c = 0;
            while (shift_load_n_out !== 1'b1 && c < 100) begin
                @(posedge clk_in);
                c++;
            end
            if (c >= 100) errors++;
        end
    endtask : wait_pulses
    // watchdog, well past the expected run length
    initial begin
        #100000;
        errors++;
        summarize();
    end
    // main sequence
    initial begin
        seed = 94324;
        errors = 0;
        n_compared = 0;
        n_upd = 0;
        upd0 = 0;
        rstn_in = 1'b0;
        net_active_in = 1'b1;
        black_channel_data_in = 1'b0;
        {mode_strap_bit3_in, mode_strap_bit2_in} = 2'b00;
        {mode_strap_bit1_in, mode_strap_bit0_in} = 2'b10;
        node_address_switch_in = 8'h00;
        rate_or_id_switch_in = 8'h00;
        n_regs = 6'h01;
        lens = '{6'h01, 6'h03, 6'h20};
        for (int k = 0; k < 32; k++) begin
            in_data[k] = 8'h00;
            out_byte_in[k] = 8'h00;
        end
        // one run per chain length, random bytes each way
        foreach (lens[j]) begin
            @(posedge clk_in);
            n_regs <= lens[j];
            net_active_in <= 1'b1;
            black_channel_data_in <= 1'($random(seed));
            for (int k = 0; k < 32; k++) begin
                in_data[k] <= 8'($random(seed));
                out_byte_in[k] <= 8'($random(seed));
            end
            do_reset(4'h2);
            wait_pulses(6);
            check({2'b00, in_count_out}, {2'b00, lens[j]});
            check({2'b00, out_count_out}, {2'b00, lens[j]});
            check(in_access_out, 8'h09);
            check(out_access_out, 8'h11);
            check({7'h00, process_active_flag_out}, 8'h01);
            check({7'h00, mode_ok_out}, 8'h01);
            check({7'h00, scan_done_out}, 8'h01);
            check({7'h00, black_channel_oe_out}, 8'h01);
            check({7'h00, black_channel_out},
                {7'h00, black_channel_data_in});
            for (int k = 0; k < 32; k++) begin
                if (k < lens[j]) begin
                    check(in_byte_out[k], in_data[k]);
                    check(latched[k], exp_latch(k, 1'b1));
                end
            end
        end
        // network leaves active state: flag drops, outputs cleared
        @(posedge clk_in);
        net_active_in <= 1'b0;
        wait_pulses(2);
        check({7'h00, process_active_flag_out}, 8'h00);
        for (int k = 0; k < 32; k++) begin
            check(latched[k], exp_latch(k, 1'b0));
        end
        // switches picked up by the periodic sample
        upd0 = n_upd;
        node_address_switch_in <= 8'($random(seed));
        rate_or_id_switch_in <= 8'($random(seed));
        repeat (150) @(posedge clk_in);
        check(node_address_out, node_address_switch_in);
        check(rate_or_id_out, rate_or_id_switch_in);
        // exactly one update pulse when either switch moved from zero
        check(8'(n_upd - upd0), {7'h00, (node_address_switch_in != 8'h00) ||
            (rate_or_id_switch_in != 8'h00)});
        // wrong strap patterns park the sequencer
        net_active_in <= 1'b1;
        do_reset(4'h3);
        repeat (60) @(posedge clk_in);
        check({7'h00, mode_ok_out}, 8'h00);
        check({7'h00, shift_load_n_out}, 8'h01);
        check({7'h00, process_active_flag_out}, 8'h00);
        do_reset(4'hA);
        repeat (60) @(posedge clk_in);
        check({7'h00, mode_ok_out}, 8'h00);
        check({7'h00, shift_clk_out}, 8'h00);
        summarize();
    end
endmodule : test_shift_scanner
`default_nettype wire
